// ---- rtl/op_decoder.sv ----
// opcode decoder for the test, transfer and wait group
`timescale 1ns/1ps
`include "xfer_test_defs.svh"
module op_decoder
(
    input  wire logic                   prefixed,
    input  wire logic [7:0]             opcode,
    output xfer_test_pkg::op_kind_t     kind,
    output xfer_test_pkg::test_src_t    src,
    output logic [2:0]                  cycles
);
    wire hit_dir = !prefixed && opcode == `OP_TEST_DIR;
    wire hit_acc = !prefixed && opcode == `OP_TEST_ACC;
    wire hit_xlo = !prefixed && opcode == `OP_TEST_XLO;
    wire hit_off8  = !prefixed && opcode == `OP_TEST_OFF8;
    wire hit_plain = !prefixed && opcode == `OP_TEST_PLAIN;
    wire hit_stk8  = prefixed && opcode == `OP_TEST_STK8;
    wire hit_s2x = !prefixed && opcode == `OP_STACK_TO_HX;
    wire hit_x2s = !prefixed && opcode == `OP_HX_TO_STACK;
    wire hit_x2a = !prefixed && opcode == `OP_XLO_TO_ACC;
    wire hit_wt  = !prefixed && opcode == `OP_WAIT;
    wire hit_test = hit_dir | hit_acc | hit_xlo | hit_off8 | hit_plain | hit_stk8;

    assign kind = hit_test ? xfer_test_pkg::OPK_TEST
                : hit_s2x ? xfer_test_pkg::OPK_SP2HX
                : hit_x2s ? xfer_test_pkg::OPK_HX2SP
                : hit_x2a ? xfer_test_pkg::OPK_X2A
                : hit_wt  ? xfer_test_pkg::OPK_WAIT
                :           xfer_test_pkg::OPK_NONE;
    assign src  = hit_acc ? xfer_test_pkg::SRC_ACC
                : hit_xlo ? xfer_test_pkg::SRC_XLO
                :           xfer_test_pkg::SRC_MEM;
    assign cycles = hit_dir ? `CYC_TEST_DIR
                  : (hit_acc | hit_xlo) ? `CYC_TEST_REG
                  : hit_off8  ? `CYC_TEST_OFF8
                  : hit_plain ? `CYC_TEST_PLAIN
                  : hit_stk8  ? `CYC_TEST_STK8
                  : (hit_s2x | hit_x2s) ? `CYC_XFER_STK
                  : hit_x2a ? `CYC_XFER_ACC
                  : hit_wt  ? `CYC_WAIT
                  :           3'h1;
endmodule

// ---- rtl/xfer_test_defs.svh ----
// constants for the test, transfer and wait instruction group
// Functional notes
// - zero test: V cleared, N Z from operand
// - zero test opcodes and cycle counts fixed
// - stack/index pair transfers, plus/minus one, flags kept
// - index low copied to accumulator, flags kept
// - wait clears interrupt mask and halts
`ifndef XFER_TEST_DEFS_SVH
`define XFER_TEST_DEFS_SVH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_TEST_DIR     8'h3D
`define OP_TEST_ACC     8'h4D
`define OP_TEST_XLO     8'h5D
`define OP_TEST_OFF8    8'h6D
`define OP_TEST_PLAIN   8'h7D
`define OP_PREFIX       8'h9E
`define OP_TEST_STK8    8'h6D
`define OP_STACK_TO_HX  8'h95
`define OP_HX_TO_STACK  8'h94
`define OP_XLO_TO_ACC   8'h9F
`define OP_WAIT         8'h8F
// ----------------------------------------
// cycle counts
// ----------------------------------------
`define CYC_TEST_DIR    3'h3
`define CYC_TEST_REG    3'h1
`define CYC_TEST_OFF8   3'h3
`define CYC_TEST_PLAIN  3'h2
`define CYC_TEST_STK8   3'h4
`define CYC_XFER_STK    3'h2
`define CYC_XFER_ACC    3'h1
`define CYC_WAIT        3'h1
// ----------------------------------------
// condition code bit positions and reset values
// ----------------------------------------
`define CC_C            0
`define CC_Z            1
`define CC_N            2
`define CC_I            3
`define CC_H            4
`define CC_V            7
`define CC_RESET        8'h68
`define STACK_RESET     16'h00FF
`endif

// ---- rtl/xfer_test_exec.sv ----
// executes the test, transfer and wait instruction group
`timescale 1ns/1ps
`include "xfer_test_defs.svh"
module xfer_test_exec
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        op_valid,
    input  wire logic        op_prefixed,
    input  wire logic [7:0]  op_code,
    input  wire logic [7:0]  mem_operand,
    input  wire logic        irq_pending,
    output logic [7:0]       acc,
    output logic [7:0]       index_high,
    output logic [7:0]       index_low,
    output logic [15:0]      stack_pointer,
    output logic [7:0]       condition_code_register,
    output logic             op_ready,
    output logic             op_done,
    output logic             op_unknown,
    output logic             wait_halted,
    output logic             irq_take
);
    // ----------------------------------------
    // decode
    // ----------------------------------------
    xfer_test_pkg::op_kind_t  kind;
    xfer_test_pkg::test_src_t src;
    logic [2:0]               cycles;

    op_decoder u_dec
    (
        .prefixed (op_prefixed),
        .opcode   (op_code),
        .kind     (kind),
        .src      (src),
        .cycles   (cycles)
    );

    // ----------------------------------------
    // state
    // ----------------------------------------
    xfer_test_pkg::exec_state_t state_r;
    xfer_test_pkg::op_kind_t    kind_r;
    logic [2:0]                 cnt_r;
    logic [7:0]                 acc_r;
    logic [7:0]                 hi_r;
    logic [7:0]                 lo_r;
    logic [15:0]                stack_r;
    logic [7:0]                 ccr_r;
    logic                       done_r;
    logic                       unk_r;
    logic                       irq_r;
    logic [7:0]                 res_r;

    wire accept = state_r == xfer_test_pkg::ST_IDLE && op_valid;
    wire [7:0] operand = src == xfer_test_pkg::SRC_ACC ? acc_r
                       : src == xfer_test_pkg::SRC_XLO ? lo_r : mem_operand;
    wire [7:0] test_res = operand - 8'h00;
    wire [15:0] stack_inc = stack_r + 16'h0001;
    wire [15:0] hx_dec = {hi_r, lo_r} - 16'h0001;
    wire last = cnt_r == 3'h1;
    wire wake = irq_pending && !ccr_r[`CC_I];

    // ----------------------------------------
    // condition code results
    // ----------------------------------------
    // overflow cleared, sign and zero from the tested byte
    wire       test_neg  = res_r[7];
    wire       test_zero = res_r == 8'h00;
    wire [7:0] ccr_test  = {1'b0, ccr_r[6:3], test_neg, test_zero, ccr_r[0]};
    // only the interrupt mask moves on wait
    wire [7:0] ccr_wait  = ccr_r & ~(8'h01 << `CC_I);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= xfer_test_pkg::ST_IDLE;
            kind_r  <= xfer_test_pkg::OPK_NONE;
            cnt_r   <= 3'h0;
            acc_r   <= 8'h00;
            hi_r    <= 8'h00;
            lo_r    <= 8'h00;
            stack_r <= `STACK_RESET;
            ccr_r   <= `CC_RESET;
            done_r  <= 1'b0;
            unk_r   <= 1'b0;
            irq_r   <= 1'b0;
            res_r   <= 8'h00;
        end
        else
        begin
            done_r <= 1'b0;
            unk_r  <= 1'b0;
            irq_r  <= 1'b0;
            case (state_r)
            xfer_test_pkg::ST_IDLE:
            begin
                if (accept)
                begin
                    kind_r <= kind;
                    cnt_r  <= cycles;
                    res_r  <= test_res;
                    unk_r  <= kind == xfer_test_pkg::OPK_NONE;
                    state_r <= xfer_test_pkg::ST_BUSY;
                end
            end
            xfer_test_pkg::ST_BUSY:
            begin
                cnt_r <= cnt_r - 3'h1;
                if (last)
                begin
                    case (kind_r)
                    xfer_test_pkg::OPK_TEST:
                    begin
                        ccr_r <= ccr_test;
                    end
                    xfer_test_pkg::OPK_SP2HX:
                    begin
                        {hi_r, lo_r} <= stack_inc;
                    end
                    xfer_test_pkg::OPK_HX2SP:
                    begin
                        stack_r <= hx_dec;
                    end
                    xfer_test_pkg::OPK_X2A:
                    begin
                        acc_r <= lo_r;
                    end
                    xfer_test_pkg::OPK_WAIT:
                    begin
                        ccr_r <= ccr_wait;
                    end
                    default:
                    begin
                        ccr_r <= ccr_r;
                    end
                    endcase
                    state_r <= kind_r == xfer_test_pkg::OPK_WAIT
                             ? xfer_test_pkg::ST_WAIT : xfer_test_pkg::ST_DONE;
                end
            end
            xfer_test_pkg::ST_WAIT:
            begin
                if (wake)
                begin
                    irq_r   <= 1'b1;
                    state_r <= xfer_test_pkg::ST_DONE;
                end
            end
            xfer_test_pkg::ST_DONE:
            begin
                done_r  <= 1'b1;
                state_r <= xfer_test_pkg::ST_IDLE;
            end
            default:
            begin
                state_r <= xfer_test_pkg::ST_IDLE;
            end
            endcase
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    logic ready_r;
    logic halt_r;

    wire ready_nxt = state_r == xfer_test_pkg::ST_IDLE && !op_valid;
    // halt drops on the wake edge so it never overlaps the wake pulse
    wire halt_nxt  = state_r == xfer_test_pkg::ST_WAIT && !wake;

    // ----------------------------------------
    // ready flag
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready_r <= 1'b0;
        end
        else
        begin
            ready_r <= ready_nxt;
        end
    end

    // ----------------------------------------
    // halt flag
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            halt_r <= 1'b0;
        end
        else
        begin
            halt_r <= halt_nxt;
        end
    end

    assign acc                     = acc_r;
    assign index_high              = hi_r;
    assign index_low               = lo_r;
    assign stack_pointer           = stack_r;
    assign condition_code_register = ccr_r;
    assign op_ready                = ready_r;
    assign op_done                 = done_r;
    assign op_unknown              = unk_r;
    assign wait_halted             = halt_r;
    assign irq_take                = irq_r;
endmodule

// ---- rtl/xfer_test_pkg.sv ----
// types for the test, transfer and wait instruction group
package xfer_test_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_BUSY = 4'h2,
        ST_WAIT = 4'h4,
        ST_DONE = 4'h8
    } exec_state_t;
    typedef enum logic [2:0] {
        OPK_NONE  = 3'h0,
        OPK_TEST  = 3'h1,
        OPK_SP2HX = 3'h2,
        OPK_HX2SP = 3'h3,
        OPK_X2A   = 3'h4,
        OPK_WAIT  = 3'h5
    } op_kind_t;
    typedef enum logic [2:0] {
        SRC_ACC = 3'h0,
        SRC_XLO = 3'h1,
        SRC_MEM = 3'h2
    } test_src_t;
endpackage

// ---- tb/xfer_test_exec_properties.sv ----
// concurrent checks on the ports of the instruction executor
`timescale 1ns/1ps
`include "xfer_test_defs.svh"
module xfer_test_exec_properties
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        op_valid,
    input wire logic        op_prefixed,
    input wire logic [7:0]  op_code,
    input wire logic        irq_pending,
    input wire logic [7:0]  acc,
    input wire logic [7:0]  index_high,
    input wire logic [7:0]  index_low,
    input wire logic [15:0] stack_pointer,
    input wire logic [7:0]  condition_code_register,
    input wire logic        op_done,
    input wire logic        irq_take
);
    // ----------------------------------------
    // accept tracking
    // ----------------------------------------
    logic       idle_r;
    wire        take = op_valid && (idle_r || op_done);
    wire        plain_take = take && !op_prefixed;
    wire  [7:0] cc   = condition_code_register;
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
            idle_r <= 1'b1;
        else
            idle_r <= take ? 1'b0 : (op_done ? 1'b1 : idle_r);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_test_acc; plain_take && op_code == `OP_TEST_ACC; endsequence
    sequence s_test_stk8; take && op_prefixed && op_code == `OP_TEST_STK8; endsequence
    sequence s_wait; plain_take && op_code == `OP_WAIT; endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_done_pulse: assert property (op_done |=> !op_done)
        else $error("done pulse too long");
    a_acc_flags: assert property (s_test_acc |-> ##2 !cc[7] && cc[2] == acc[7]
        && cc[1] == (acc == 8'h00) && (cc & 8'h79) == ($past(cc, 2) & 8'h79))
        else $error("accumulator test flags wrong");
    a_stk8_timing: assert property (s_test_stk8 |-> ##1 !op_done [*5] ##1 op_done)
        else $error("stack offset test timing wrong");
    a_stack_to_pair: assert property (plain_take && op_code == `OP_STACK_TO_HX |-> ##3
        {index_high, index_low} == $past(stack_pointer, 3) + 16'h0001 && cc == $past(cc, 3))
        else $error("stack to pair wrong");
    a_pair_to_stack: assert property (plain_take && op_code == `OP_HX_TO_STACK |-> ##3
        stack_pointer == $past({index_high, index_low}, 3) - 16'h0001 && cc == $past(cc, 3))
        else $error("pair to stack wrong");
    a_low_copy: assert property (plain_take && op_code == `OP_XLO_TO_ACC |-> ##2
        acc == index_low && cc == $past(cc, 2))
        else $error("index low copy wrong");
    a_wait_mask: assert property (s_wait |-> ##2 !cc[3])
        else $error("wait kept mask set");
    a_irq_wake: assert property (irq_take |-> ($past(irq_pending) && !cc[3]) ##1 op_done)
        else $error("wake without request");
endmodule

// ---- tb/xfer_test_exec_tb.sv ----
// self-checking bench for the test, transfer and wait group
`timescale 1ns/1ps
module xfer_test_exec_tb;
    logic        mclk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, op_prefixed = 1'b0;
    logic        irq_pending = 1'b0, op_ready, op_done, op_unknown, wait_halted, irq_take;
    logic [7:0]  op_code = 8'h00, mem_operand = 8'h00, acc, index_high, index_low;
    logic [7:0]  condition_code_register, cyc = 8'h00;
    logic [15:0] stack_pointer, e_stack = 16'h00FF;
    logic [7:0]  e_acc = 8'h00, e_h = 8'h00, e_x = 8'h00, e_cc = 8'h68;
    logic [55:0] note;
    logic [55:0] notes[$];
    logic [31:0] seed = 32'h1A268281;
    logic [7:0]  forms[6] = '{8'h3D, 8'h4D, 8'h5D, 8'h6D, 8'h7D, 8'h6D};
    logic [7:0]  lens[6] = '{8'h03, 8'h01, 8'h01, 8'h03, 8'h02, 8'h04};
    int          errors = 0, cmp_count = 0, ticks = 0, unk_seen = 0;
    xfer_test_exec dut (.*);
    always #50 mclk = ~mclk;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task automatic check(logic ok, string what);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // model the effect, note it, then offer the opcode until done
    task automatic run(logic pfx, logic [7:0] op, logic [7:0] mem, logic [7:0] n);
        logic [7:0] s;
        s = op == 8'h4D ? e_acc : (op == 8'h5D ? e_x : mem);
        if (op[3:0] == 4'hD && op < 8'h80)
            e_cc = {1'b0, e_cc[6:3], s[7], s == 8'h00, e_cc[0]};
        if (op == 8'h95)
            {e_h, e_x} = e_stack + 16'h0001;
        if (op == 8'h94)
            e_stack = {e_h, e_x} - 16'h0001;
        if (op == 8'h9F)
            e_acc = e_x;
        if (op == 8'h8F)
            e_cc[3] = 1'b0;
        notes.push_back({n == 8'h00 ? 8'h00 : n + 8'h02, e_acc, e_h, e_x, e_stack, e_cc});
        @(posedge mclk);
        #1 {op_valid, op_prefixed, op_code, mem_operand} = {1'b1, pfx, op, mem};
        if (op == 8'h8F)
        begin
            wait (wait_halted === 1'b1);
            #1 irq_pending = 1'b1;
        end
        wait (op_done === 1'b1);
        #1 {op_valid, irq_pending} = 2'b00;
    endtask
    // ----------------------------------------
    // result monitor
    // ----------------------------------------
    always @(negedge mclk)
    begin
        cyc <= op_valid ? cyc + 8'h01 : 8'h00;
        if (op_unknown === 1'b1)
            unk_seen++;
        if (irq_take === 1'b1)
            check(condition_code_register[3] === 1'b0 && wait_halted === 1'b0, "wake");
        if (op_done === 1'b1)
        begin
            note = notes.pop_front();
            if (note[55:48] != 8'h00)
                check(cyc === note[55:48], "cycle count");
            check({acc, index_high, index_low, stack_pointer, condition_code_register}
                === note[47:0], "register state");
        end
    end
    always @(posedge mclk)
        if (++ticks > 3000)
        begin
            errors++;
            finish_test();
        end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (5) @(posedge mclk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 18; i++)
        begin
            seed = xs(seed);
            run(i % 6 == 5, forms[i % 6], i < 6 ? 8'h00 : (i < 12 ? 8'h80 : seed[7:0]),
                lens[i % 6]);
        end
        run(1'b0, 8'h95, seed[15:8], 8'h02);
        run(1'b0, 8'h5D, seed[23:16], 8'h01);
        run(1'b0, 8'h9F, 8'h00, 8'h01);
        run(1'b0, 8'h94, 8'h00, 8'h02);
        run(1'b0, 8'h8F, 8'h00, 8'h00);
        run(1'b0, 8'h4D, 8'h00, 8'h01);
        run(1'b0, 8'h9D, 8'h00, 8'h01);
        check(unk_seen == 1, "unknown opcode flag");
        finish_test();
    end
endmodule
bind xfer_test_exec xfer_test_exec_properties u_props (.*);
